// >>> logic/wdog_cfg.svh
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH
`define WDOG_CTRL_ADDR 8'hc0
`define WDOG_CTRL_RESET 8'h10
`define WDOG_PRE_MSB 7
`define WDOG_PRE_LSB 4
`define WDOG_IRQ_SEL_BIT 3
`define WDOG_STATUS_BIT 2
`define WDOG_RUN_BIT 1
`define WDOG_UNLOCK_BIT 0
`define WDOG_BASE_LOG2 9
`define WDOG_PRE_MAX 4'h7
`define WDOG_PRE_IMMEDIATE 4'h8
`endif

// >>> logic/wdog_pkg.sv
package wdog_pkg;
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN = 2'b01,
    WD_FIRE = 2'b11
  } wd_state_type;
endpackage

// >>> logic/tick_sync.sv
`timescale 1ns/1ps
module tick_sync (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow_clk,
  output logic tick
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic tick;
  } sync_state_type;
  sync_state_type st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.s1 = slow_clk;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.tick = st_reg.s2 & ~st_reg.s3;
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign tick = st_reg.tick;
endmodule

// >>> logic/watchdog_timeout_unit.sv
`timescale 1ns/1ps
`include "wdog_cfg.svh"
// How it works
// R1: with the run bit clear the watchdog neither resets nor interrupts; the code still fires once if the run bit clears as the state enters WD_FIRE.
// R2: while running, a timeout without re-arming fires a reset or an interrupt.
// R3: the counter advances on rising edges of the 32 kHz low-speed clock.
// R4: a control write is taken only in the instruction right after setting the unlock bit.
// R5: timeout is 2 to the prescale times 2^9 low-speed periods for prescale 0 to 7.
// R6: prescale sits in bits 7..4; code 8 resets at once, codes above 8 are reserved.
// R7: with the irq select bit set, a timeout raises an interrupt instead of a reset.
// R8: the interrupt ignores the global enable and is fixed high priority.
// R9: every timeout sets the status bit.
// R10: the status bit clears only by a written 0 or an external reset, not by a watchdog reset.
// R11: setting the run bit enables the watchdog and clears its counters.
// R12: the run bit clears on a written 0, a watchdog reset in reset mode, hard reset or supply monitor event.
// R13: in interrupt mode the watchdog interrupts repeatedly at the selected period.
// R14: the unlock bit clears after the next instruction whether or not it wrote the register.
module watchdog_timeout_unit #(
  parameter int CNT_W = 17
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow_clk,
  input wire logic instr_done,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_addr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic unlock_set,
  input wire logic supply_monitor,
  output logic [7:0] ctrl_rdata,
  output logic wdog_reset,
  output logic wdog_irq
);
  import wdog_pkg::*;
  typedef struct packed {
    wd_state_type state;
    logic [3:0] timeout_prescale;
    logic timeout_irq_select;
    logic timeout_status_flag;
    logic wdog_run_bit;
    logic write_unlock_bit;
    logic unlock_armed;
    logic [CNT_W-1:0] count;
    logic [7:0] rdata;
    logic wdog_reset;
    logic wdog_irq;
  } wd_reg_type;
  wd_reg_type r_reg, r_next;
  logic tick;
  logic [CNT_W-1:0] limit;
  logic wr_hit;
  logic expired;
  logic immediate;
  tick_sync u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .slow_clk(slow_clk),
    .tick(tick)
  );
  // timeout in slow periods, minus one so the compare hits on the last tick
  assign limit = CNT_W'((1 << (`WDOG_BASE_LOG2 + r_reg.timeout_prescale[2:0])) - 1); // R5
  assign wr_hit = ctrl_wr && ctrl_addr == `WDOG_CTRL_ADDR && r_reg.unlock_armed; // R4
  assign immediate = r_reg.timeout_prescale == `WDOG_PRE_IMMEDIATE; // R6
  assign expired = tick && r_reg.count == limit && r_reg.timeout_prescale <= `WDOG_PRE_MAX;
  always_comb begin
    r_next = r_reg;
    r_next.wdog_reset = 1'b0;
    r_next.wdog_irq = 1'b0;
    if (unlock_set) begin
      r_next.write_unlock_bit = 1'b1;
      r_next.unlock_armed = 1'b0;
    end else if (instr_done && r_reg.write_unlock_bit) begin
      r_next.unlock_armed = 1'b1;
      r_next.write_unlock_bit = 1'b0;
    end else if (instr_done && r_reg.unlock_armed) begin
      r_next.unlock_armed = 1'b0; // R14
    end
    if (tick && r_reg.wdog_run_bit) begin
      r_next.count = r_reg.count + CNT_W'(1); // R3
    end
    case (r_reg.state)
      WD_IDLE: begin
        r_next.count = '0; // R1
        if (r_reg.wdog_run_bit) begin
          r_next.state = WD_RUN;
        end
      end
      WD_RUN: begin
        if (!r_reg.wdog_run_bit) begin
          r_next.state = WD_IDLE;
        end else if (expired || immediate) begin // R2
          r_next.state = WD_FIRE;
        end
      end
      WD_FIRE: begin
        r_next.count = '0;
        r_next.timeout_status_flag = 1'b1; // R9
        if (r_reg.timeout_irq_select && !immediate) begin
          r_next.wdog_irq = 1'b1; // R7 R8 R13
          r_next.state = WD_RUN;
        end else begin
          r_next.wdog_reset = 1'b1; // R6
          r_next.wdog_run_bit = 1'b0; // R12
          r_next.state = WD_IDLE;
        end
      end
      default: begin
        r_next.state = WD_IDLE;
      end
    endcase
    if (wr_hit) begin
      r_next.unlock_armed = 1'b0;
      r_next.timeout_prescale = ctrl_wdata[`WDOG_PRE_MSB:`WDOG_PRE_LSB];
      r_next.timeout_irq_select = ctrl_wdata[`WDOG_IRQ_SEL_BIT];
      // a timeout in the same cycle wins over a cleared status bit
      if (!ctrl_wdata[`WDOG_STATUS_BIT] && r_reg.state != WD_FIRE) begin
        r_next.timeout_status_flag = 1'b0; // R10
      end
      r_next.wdog_run_bit = ctrl_wdata[`WDOG_RUN_BIT]; // R12
      if (ctrl_wdata[`WDOG_RUN_BIT]) begin
        r_next.count = '0; // R11
        r_next.state = WD_RUN;
      end
    end
    if (supply_monitor) begin
      r_next.wdog_run_bit = 1'b0; // R12
    end
    // a watchdog reset outranks a write landing in the same cycle
    if (r_next.wdog_reset) begin
      r_next.wdog_run_bit = 1'b0; // R12
      r_next.state = WD_IDLE;
    end
    r_next.rdata = {r_next.timeout_prescale, r_next.timeout_irq_select, r_next.timeout_status_flag,
                    r_next.wdog_run_bit, r_next.write_unlock_bit};
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r_reg <= '0;
      r_reg.timeout_prescale <= 4'(`WDOG_CTRL_RESET >> `WDOG_PRE_LSB);
      r_reg.rdata <= `WDOG_CTRL_RESET;
      r_reg.state <= WD_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end
  assign ctrl_rdata = r_reg.rdata;
  assign wdog_reset = r_reg.wdog_reset;
  assign wdog_irq = r_reg.wdog_irq;
  // every check runs on sys_clk and sleeps while reset is high
  AST_IDLE_QUIET: assert property (@(posedge sys_clk) disable iff (reset) // R1
    (r_reg.state == WD_IDLE && !r_reg.wdog_run_bit) |=> !wdog_reset && !wdog_irq)
    else $error("watchdog fired while stopped");
  AST_STATUS_SET: assert property (@(posedge sys_clk) disable iff (reset) // R9
    (wdog_reset || wdog_irq) |-> r_reg.timeout_status_flag)
    else $error("status not set on timeout");
  AST_IRQ_MODE: assert property (@(posedge sys_clk) disable iff (reset) // R7
    wdog_irq |-> !wdog_reset && $past(r_reg.timeout_irq_select))
    else $error("irq without irq select");
  AST_RESET_CLEARS_RUN: assert property (@(posedge sys_clk) disable iff (reset) // R12
    wdog_reset |-> !r_reg.wdog_run_bit)
    else $error("run bit kept after watchdog reset");
  AST_LOCKED_WRITE: assert property (@(posedge sys_clk) disable iff (reset) // R4
    (ctrl_wr && !r_reg.unlock_armed && !supply_monitor && r_reg.state != WD_FIRE)
    |=> $stable(r_reg.timeout_prescale) && $stable(r_reg.timeout_irq_select))
    else $error("locked write took effect");
  AST_UNLOCK_EXPIRES: assert property (@(posedge sys_clk) disable iff (reset) // R14
    (r_reg.unlock_armed && instr_done && !unlock_set) |=> !r_reg.unlock_armed)
    else $error("unlock outlived next instruction");
  AST_UNLOCK_ARMS: assert property (@(posedge sys_clk) disable iff (reset) // R4 R14
    (r_reg.write_unlock_bit && instr_done && !unlock_set) |=> r_reg.unlock_armed && !r_reg.write_unlock_bit)
    else $error("unlock did not arm the next instruction");
  // a watchdog reset in the same cycle keeps the run bit low
  AST_ARM_CLEARS: assert property (@(posedge sys_clk) disable iff (reset) // R11
    (wr_hit && ctrl_wdata[`WDOG_RUN_BIT] && !supply_monitor && r_reg.state != WD_FIRE)
    |=> r_reg.count == '0 && r_reg.wdog_run_bit)
    else $error("arming did not clear counter");
  AST_TIMEOUT_FIRES: assert property (@(posedge sys_clk) disable iff (reset) // R2 R5
    (r_reg.state == WD_RUN && r_reg.wdog_run_bit && expired && !wr_hit && !supply_monitor)
    |=> ##1 (wdog_reset || wdog_irq))
    else $error("timeout did not fire");
  AST_STATUS_STICKY: assert property (@(posedge sys_clk) disable iff (reset) // R10
    (r_reg.timeout_status_flag && !wr_hit) |=> r_reg.timeout_status_flag)
    else $error("status cleared without write");
  AST_FIRE_SETS_STATUS: assert property (@(posedge sys_clk) disable iff (reset) // R9 R10
    r_reg.state == WD_FIRE |=> r_reg.timeout_status_flag)
    else $error("status not set after firing");
  AST_RESET_MODE: assert property (@(posedge sys_clk) disable iff (reset) // R7
    (r_reg.state == WD_FIRE && !r_reg.timeout_irq_select) |=> wdog_reset && !wdog_irq)
    else $error("reset mode did not reset");
  AST_RESET_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (reset) // R2
    wdog_reset |=> !wdog_reset)
    else $error("reset request longer than one cycle");
  AST_IRQ_RESTARTS: assert property (@(posedge sys_clk) disable iff (reset) // R13
    wdog_irq |-> r_reg.state == WD_RUN && r_reg.count == '0)
    else $error("interval timer did not restart");
  AST_IRQ_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (reset) // R13
    wdog_irq |=> !wdog_irq)
    else $error("interrupt longer than one cycle");
  AST_SUPPLY_STOPS: assert property (@(posedge sys_clk) disable iff (reset) // R12
    supply_monitor |=> !r_reg.wdog_run_bit)
    else $error("supply event left watchdog running");
  AST_STOPPED_COUNT: assert property (@(posedge sys_clk) disable iff (reset) // R1
    (r_reg.state == WD_IDLE && !r_reg.wdog_run_bit && !wr_hit) |=> r_reg.count == '0)
    else $error("counter moved while stopped");
  // reserved prescale codes keep counting but never fire
  AST_RESERVED_QUIET: assert property (@(posedge sys_clk) disable iff (reset) // R6
    (r_reg.state == WD_RUN && r_reg.timeout_prescale > `WDOG_PRE_IMMEDIATE) |=> r_reg.state != WD_FIRE)
    else $error("reserved code fired");
  // the counter moves only on a synchronised slow edge
  sequence seq_counting;
    r_reg.state == WD_RUN && r_reg.wdog_run_bit && !wr_hit;
  endsequence
  AST_COUNT_HOLD: assert property (@(posedge sys_clk) disable iff (reset) // R3
    seq_counting ##0 !tick |=> $stable(r_reg.count))
    else $error("counter moved without slow edge");
  AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (reset) // R3 R5
    seq_counting ##0 tick |=> r_reg.count == CNT_W'($past(r_reg.count) + 1))
    else $error("counter missed a slow edge");
  sequence seq_immediate_armed;
    r_reg.state == WD_RUN && r_reg.wdog_run_bit && immediate
    && !wr_hit && !supply_monitor;
  endsequence
  sequence seq_reset_pulse;
    ##1 wdog_reset;
  endsequence
  AST_IMMEDIATE_RESET: assert property (@(posedge sys_clk) disable iff (reset) // R6
    seq_immediate_armed |=> seq_reset_pulse)
    else $error("immediate code did not reset");
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 0, reset = 1, slow_clk = 0, instr_done = 0, ctrl_wr = 0, unlock_set = 0, supply_monitor = 0;
  logic [7:0] ctrl_addr = 8'hc0, ctrl_wdata = 8'h00;
  logic [7:0] ctrl_rdata;
  logic wdog_reset, wdog_irq;
  int failures = 0, samples_checked = 0, n, irqs_seen = 0, resets_seen = 0, i0, r0;
  always #4 sys_clk = ~sys_clk;
  // slow clock far above 32 khz so whole timeouts fit the run
  always begin
    repeat (4) @(posedge sys_clk);
    #1;
    slow_clk = ~slow_clk;
  end
  // counted mid-cycle, away from the edge that launches the pulses
  always @(negedge sys_clk) begin
    if (wdog_irq === 1'b1) irqs_seen++;
    if (wdog_reset === 1'b1) resets_seen++;
  end
  watchdog_timeout_unit dut (.sys_clk(sys_clk), .reset(reset), .slow_clk(slow_clk), .instr_done(instr_done),
    .ctrl_wr(ctrl_wr), .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .unlock_set(unlock_set),
    .supply_monitor(supply_monitor), .ctrl_rdata(ctrl_rdata), .wdog_reset(wdog_reset), .wdog_irq(wdog_irq));
  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  // write lands with the second instruction; unlocked=0 skips the unlock step
  task automatic wr(input logic [7:0] d, input logic unlocked);
    unlock_set = unlocked;
    step(1);
    unlock_set = 0;
    instr_done = 1;
    step(1);
    ctrl_wr = 1;
    ctrl_wdata = d;
    step(1);
    ctrl_wr = 0;
    instr_done = 0;
    step(1);
  endtask
  task automatic wait_evt(input bit want_irq, input int bound, output int cnt);
    cnt = 0;
    do begin
      step(1);
      cnt++;
    end while ((want_irq ? wdog_irq : wdog_reset) !== 1'b1 && cnt < bound);
    if (cnt >= bound) begin
      failures++;
      $display("mismatch at %0t: no watchdog event", $time);
      print_verdict();
    end
  endtask
  task automatic t_locked();
    check(ctrl_rdata, 8'h10, "reset value");
    wr(8'h0a, 0);
    check(ctrl_rdata, 8'h10, "locked write taken");
    ctrl_addr = 8'hc1;
    wr(8'h0a, 1);
    ctrl_addr = 8'hc0;
    check(ctrl_rdata, 8'h10, "other address taken");
    unlock_set = 1;
    step(1);
    unlock_set = 0;
    check(ctrl_rdata, 8'h11, "unlock bit readback");
    instr_done = 1;
    step(2);
    instr_done = 0;
    ctrl_wr = 1;
    ctrl_wdata = 8'h0a;
    step(1);
    ctrl_wr = 0;
    step(1);
    check(ctrl_rdata, 8'h10, "write after expired unlock");
    $display("done locked");
  endtask
  task automatic t_irq_mode();
    wr(8'h0a, 1);
    check(ctrl_rdata, 8'h0a, "unlocked write");
    wait_evt(1, 5000, n);
    check(8'(n >= 4070 && n <= 4130), 8'h01, "first period");
    check(ctrl_rdata, 8'h0e, "status after irq");
    check(8'(resets_seen), 8'h00, "reset in irq mode");
    wait_evt(1, 5000, n);
    check(8'(n >= 4070 && n <= 4130), 8'h01, "repeat period");
    $display("done irq mode");
  endtask
  task automatic t_stopped();
    wr(8'h00, 1);
    check(ctrl_rdata, 8'h00, "run and status cleared");
    i0 = irqs_seen;
    r0 = resets_seen;
    step(9000);
    check(8'(irqs_seen - i0 + resets_seen - r0), 8'h00, "event while stopped");
    wr(8'h92, 1);
    check(ctrl_rdata, 8'h92, "reserved code written");
    i0 = irqs_seen;
    r0 = resets_seen;
    step(9000);
    check(8'(irqs_seen - i0 + resets_seen - r0), 8'h00, "reserved code fired");
    $display("done stopped");
  endtask
  task automatic t_rearm();
    wr(8'h0a, 1);
    i0 = irqs_seen;
    step(3000);
    wr(8'h0a, 1);
    step(3000);
    // rearm restarted the count, so 6000 cycles stay quiet
    check(8'(irqs_seen - i0), 8'h00, "irq despite rearm");
    $display("done rearm");
  endtask
  task automatic t_immediate();
    wr(8'h82, 1);
    wait_evt(0, 8, n);
    step(2);
    check(ctrl_rdata, 8'h84, "after immediate reset");
    reset = 1;
    step(2);
    reset = 0;
    check(ctrl_rdata, 8'h10, "hard reset");
    $display("done immediate");
  endtask
  task automatic t_supply();
    wr(8'h0a, 1);
    supply_monitor = 1;
    step(1);
    supply_monitor = 0;
    step(1);
    check(ctrl_rdata, 8'h08, "supply monitor");
    $display("done supply");
  endtask
  initial begin
    step(8);
    reset = 0;
    t_locked();
    t_irq_mode();
    t_stopped();
    t_rearm();
    t_immediate();
    t_supply();
    print_verdict();
  end
endmodule
